/* ptc_pkg.sv */
// Package with constants, register map and carrier types of the stamp capture
package ptc_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned PTC_CLK_FREQ_HZ = 50_000_000;
    localparam int unsigned PTC_NS_PER_S = 1_000_000_000;
    // Nanoseconds advanced per reference clock in the default setup
    localparam int unsigned PTC_CLK_PERIOD_NS = PTC_NS_PER_S / PTC_CLK_FREQ_HZ;
    // Least spacing of two captures, in both clocks
    localparam logic [1:0] PTC_CAPTURE_GAP = 2'h3;

    // ************************************************************
    // Time format
    // ************************************************************
    localparam logic [31:0] PTC_NS_MAX_DIGITAL = 32'h3B9A_C9FF;
    localparam logic [31:0] PTC_NS_MAX_BINARY = 32'h7FFF_FFFF;
    localparam logic [31:0] PTC_WORD_ONES = 32'hFFFF_FFFF;
    localparam logic [31:0] PTC_WORD_ZERO = 32'h0000_0000;

    // ************************************************************
    // Register map (byte addresses) and fields
    // ************************************************************
    localparam int PTC_AW = 6;
    localparam logic [5:0] PTC_REG_CTRL = 6'h00;
    localparam logic [5:0] PTC_REG_INCR = 6'h04;
    localparam logic [5:0] PTC_REG_SEC = 6'h08;
    localparam logic [5:0] PTC_REG_NS = 6'h0C;
    localparam logic [5:0] PTC_REG_SEC_HI = 6'h10;
    localparam logic [5:0] PTC_REG_STATUS = 6'h14;
    localparam logic [5:0] PTC_REG_PPS = 6'h18;
    localparam int PTC_CTRL_ENABLE_BIT = 0;
    localparam int PTC_CTRL_FORMAT_BIT = 1;
    localparam int PTC_STATUS_OVF_BIT = 0;
    localparam logic [1:0] PTC_CTRL_RESET = 2'h2;
    localparam logic [7:0] PTC_INCR_RESET = 8'(PTC_CLK_PERIOD_NS);
    localparam logic [7:0] PTC_PPS_RESET = 8'h01;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [15:0] sec_hi;
        logic [31:0] sec;
        logic [31:0] ns;
    } ptc_time_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [PTC_AW-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } ptc_avs_req_t;

    typedef struct packed {
        logic valid;
        logic stamp_ok;
        logic [31:0] status;
        logic [31:0] tx_desc_stamp_low_word;
        logic [31:0] tx_desc_stamp_high_word;
    } ptc_txwb_t;

    typedef struct packed {
        logic valid;
        logic stamp_we;
        logic [31:0] rx_desc_stamp_low_word;
        logic [31:0] rx_desc_stamp_high_word;
    } ptc_rxwb_t;

    typedef struct packed {
        ptc_time_t now;
        logic [1:0] ctrl;
        logic [7:0] incr;
        logic [7:0] pps_int;
        logic [7:0] pps_cnt;
        logic pps;
        logic ovf;
        logic [1:0] phy_clk_s;
        logic [1:0] tx_sfd_s;
        logic [1:0] rx_sfd_s;
        logic [1:0] tx_req_s;
        logic phy_clk_prev;
        logic tx_sfd_prev;
        logic rx_sfd_prev;
        logic [1:0] phy_gap;
        logic [1:0] clk_gap;
        logic [63:0] tx_stamp;
        logic tx_stamp_ok;
        logic [63:0] rx_stamp;
        logic rx_stamp_ok;
        ptc_txwb_t txwb;
        ptc_rxwb_t rxwb;
        logic ack;
        logic [31:0] rdata;
    } ptc_state_t;

    localparam ptc_state_t PTC_STATE_RESET = '{
        ctrl: PTC_CTRL_RESET,
        incr: PTC_INCR_RESET,
        pps_int: PTC_PPS_RESET,
        phy_gap: PTC_CAPTURE_GAP,
        clk_gap: PTC_CAPTURE_GAP,
        default: '0
    };

endpackage : ptc_pkg

/* ptc_timestamp_capture.sv */
// Stamp capture block: reference time, SFD capture, descriptor write-back
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module ptc_timestamp_capture
    import ptc_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire ptc_avs_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic phy_clk,
    input wire logic tx_sfd,
    input wire logic tx_stamp_req,
    input wire logic rx_sfd,
    input wire logic tx_frame_done,
    input wire logic [31:0] tx_status,
    input wire logic rx_frame_done,
    input wire logic rx_last_desc,
    input wire logic rx_overflow,
    output ptc_txwb_t tx_wb,
    output ptc_rxwb_t rx_wb,
    output logic pps_out,
    output ptc_time_t time_now
);

    // ************************************************************
    // State
    // ************************************************************
    ptc_state_t s_q;
    ptc_state_t s_d;
    logic req_any;
    logic req_take;

    // Byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] ptc_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : ptc_merge

    // Request stands for one waited cycle, taken when ack is high
    assign req_any = avs_req.read | avs_req.write;
    assign req_take = req_any & s_q.ack;
    assign avs_waitrequest = req_any & ~s_q.ack;
    assign avs_readdata = s_q.rdata;
    assign tx_wb = s_q.txwb;
    assign rx_wb = s_q.rxwb;
    assign pps_out = s_q.pps;
    assign time_now = s_q.now;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [32:0] ns_sum;
        logic [31:0] ns_max;
        logic carry;
        logic sec_wrap;
        logic phy_rise;
        logic gap_ok;
        logic tx_edge;
        logic rx_edge;
        logic tx_cap;
        logic rx_cap;
        logic ovf_set;
        logic ovf_clr;
        logic [7:0] pps_next;
        logic [31:0] rd;
        ns_sum = '0;
        ns_max = '0;
        carry = 1'b0;
        sec_wrap = 1'b0;
        phy_rise = 1'b0;
        gap_ok = 1'b0;
        tx_edge = 1'b0;
        rx_edge = 1'b0;
        tx_cap = 1'b0;
        rx_cap = 1'b0;
        ovf_set = 1'b0;
        ovf_clr = 1'b0;
        pps_next = '0;
        rd = PTC_WORD_ZERO;
        s_d = s_q;

        // Time advance; the format bit picks the nanosecond limit
        ns_max = s_q.ctrl[PTC_CTRL_FORMAT_BIT] ? PTC_NS_MAX_DIGITAL
                                               : PTC_NS_MAX_BINARY;
        ns_sum = {1'b0, s_q.now.ns} + {25'h0, s_q.incr};
        carry = ns_sum > {1'b0, ns_max};
        if (carry)
        begin
            // Remainder kept so a step above one loses no time
            s_d.now.ns = 32'(ns_sum - {1'b0, ns_max} - 33'h1);
            s_d.now.sec = s_q.now.sec + 32'h1;
            sec_wrap = s_q.now.sec == PTC_WORD_ONES;
            if (sec_wrap)
            begin
                s_d.now.sec_hi = s_q.now.sec_hi + 16'h1;
            end
        end
        else
        begin
            s_d.now.ns = ns_sum[31:0];
        end

        // Pulse every pps_int seconds; zero acts as one
        s_d.pps = 1'b0;
        if (carry)
        begin
            pps_next = s_q.pps_cnt + 8'h1;
            if (pps_next >= s_q.pps_int)
            begin
                s_d.pps = 1'b1;
                s_d.pps_cnt = '0;
            end
            else
            begin
                s_d.pps_cnt = pps_next;
            end
        end

        // Two-flop synchronisers; only stage one feeds stage two
        s_d.phy_clk_s = {s_q.phy_clk_s[0], phy_clk};
        s_d.tx_sfd_s = {s_q.tx_sfd_s[0], tx_sfd};
        s_d.rx_sfd_s = {s_q.rx_sfd_s[0], rx_sfd};
        s_d.tx_req_s = {s_q.tx_req_s[0], tx_stamp_req};
        s_d.phy_clk_prev = s_q.phy_clk_s[1];
        phy_rise = s_q.phy_clk_s[1] & ~s_q.phy_clk_prev;

        // SFD edges judged at PHY clock edges, as the PHY logic would
        if (phy_rise)
        begin
            s_d.tx_sfd_prev = s_q.tx_sfd_s[1];
            s_d.rx_sfd_prev = s_q.rx_sfd_s[1];
            tx_edge = s_q.tx_sfd_s[1] & ~s_q.tx_sfd_prev;
            rx_edge = s_q.rx_sfd_s[1] & ~s_q.rx_sfd_prev;
            if (s_q.phy_gap != PTC_CAPTURE_GAP)
            begin
                s_d.phy_gap = s_q.phy_gap + 2'h1;
            end
        end
        if (s_q.clk_gap != PTC_CAPTURE_GAP)
        begin
            s_d.clk_gap = s_q.clk_gap + 2'h1;
        end

        // Captures too close in either clock are dropped
        gap_ok = (s_q.phy_gap == PTC_CAPTURE_GAP)
                 && (s_q.clk_gap == PTC_CAPTURE_GAP);
        tx_cap = gap_ok && tx_edge && s_q.tx_req_s[1]
                 && s_q.ctrl[PTC_CTRL_ENABLE_BIT];
        rx_cap = gap_ok && rx_edge && !tx_cap
                 && s_q.ctrl[PTC_CTRL_ENABLE_BIT];
        if (tx_cap || rx_cap)
        begin
            s_d.phy_gap = '0;
            s_d.clk_gap = '0;
        end
        // Sync latency is fixed, so the stamp lags the SFD by a constant
        if (tx_cap)
        begin
            s_d.tx_stamp = {s_q.now.sec, s_q.now.ns};
            s_d.tx_stamp_ok = 1'b1;
        end
        if (rx_cap)
        begin
            s_d.rx_stamp = {s_q.now.sec, s_q.now.ns};
            s_d.rx_stamp_ok = 1'b1;
        end

        // Transmit write-back carries status and stamp together
        s_d.txwb.valid = 1'b0;
        if (tx_frame_done)
        begin
            s_d.txwb.valid = 1'b1;
            s_d.txwb.status = tx_status;
            s_d.txwb.stamp_ok = s_q.tx_stamp_ok;
            s_d.txwb.tx_desc_stamp_low_word = s_q.tx_stamp[31:0];
            s_d.txwb.tx_desc_stamp_high_word = s_q.tx_stamp[63:32];
            s_d.tx_stamp_ok = tx_cap;
        end

        // Receive write-back: last descriptor only, ones when invalid
        s_d.rxwb.valid = 1'b0;
        s_d.rxwb.stamp_we = 1'b0;
        if (rx_frame_done)
        begin
            s_d.rxwb.valid = 1'b1;
            s_d.rxwb.stamp_we = rx_last_desc
                                && s_q.ctrl[PTC_CTRL_ENABLE_BIT];
            if (rx_last_desc)
            begin
                s_d.rx_stamp_ok = rx_cap;
                if (s_q.rx_stamp_ok && !rx_overflow)
                begin
                    s_d.rxwb.rx_desc_stamp_low_word = s_q.rx_stamp[31:0];
                    s_d.rxwb.rx_desc_stamp_high_word = s_q.rx_stamp[63:32];
                end
                else
                begin
                    s_d.rxwb.rx_desc_stamp_low_word = PTC_WORD_ONES;
                    s_d.rxwb.rx_desc_stamp_high_word = PTC_WORD_ONES;
                end
            end
        end

        // Register read mux; unmapped addresses read zero
        unique case (avs_req.address)
            PTC_REG_CTRL: rd = {30'h0, s_q.ctrl};
            PTC_REG_INCR: rd = {24'h0, s_q.incr};
            PTC_REG_SEC: rd = s_q.now.sec;
            PTC_REG_NS: rd = s_q.now.ns;
            PTC_REG_SEC_HI: rd = {16'h0, s_q.now.sec_hi};
            PTC_REG_STATUS: rd = {31'h0, s_q.ovf};
            PTC_REG_PPS: rd = {24'h0, s_q.pps_int};
            default: rd = PTC_WORD_ZERO;
        endcase

        // Bus answer one cycle after the request appears
        s_d.ack = req_any & ~s_q.ack;
        if (req_any && !s_q.ack)
        begin
            s_d.rdata = avs_req.read ? rd : PTC_WORD_ZERO;
        end
        if (req_take && avs_req.write)
        begin
            unique case (avs_req.address)
                PTC_REG_CTRL: s_d.ctrl = 2'(ptc_merge({30'h0, s_q.ctrl},
                    avs_req.writedata, avs_req.byteenable));
                PTC_REG_INCR: s_d.incr = 8'(ptc_merge({24'h0, s_q.incr},
                    avs_req.writedata, avs_req.byteenable));
                PTC_REG_PPS: s_d.pps_int = 8'(ptc_merge({24'h0, s_q.pps_int},
                    avs_req.writedata, avs_req.byteenable));
                PTC_REG_STATUS: ovf_clr = avs_req.byteenable[0]
                    && avs_req.writedata[PTC_STATUS_OVF_BIT];
                default: ovf_clr = 1'b0;
            endcase
        end

        // Overflow flag: write one to clear, a new overflow wins
        ovf_set = carry && sec_wrap;
        s_d.ovf = (s_q.ovf && !ovf_clr) || ovf_set;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            s_q <= PTC_STATE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence ptc_rx_bad_end;
        rx_frame_done && rx_last_desc && rx_overflow;
    endsequence

    sequence ptc_rx_ones_out;
        rx_wb.valid && rx_wb.rx_desc_stamp_low_word == PTC_WORD_ONES
        && rx_wb.rx_desc_stamp_high_word == PTC_WORD_ONES;
    endsequence

    digital_ns_bound_a: assert property (
        s_q.ctrl[PTC_CTRL_FORMAT_BIT] && s_q.now.ns <= PTC_NS_MAX_DIGITAL
        |=> s_q.now.ns <= PTC_NS_MAX_DIGITAL)
        else $error("nanoseconds above digital limit");

    binary_ns_wrap_a: assert property (
        !s_q.ctrl[PTC_CTRL_FORMAT_BIT] && s_q.now.ns == PTC_NS_MAX_BINARY
        && s_q.incr == 8'h01 && !req_take
        |=> s_q.now.ns == PTC_WORD_ZERO && s_q.now.sec == $past(s_q.now.sec) + 32'h1)
        else $error("binary rollover did not advance seconds");

    sec_overflow_flag_a: assert property (
        s_q.now.sec == PTC_WORD_ONES ##1 s_q.now.sec == PTC_WORD_ZERO
        |-> s_q.ovf && s_q.now.sec_hi == $past(s_q.now.sec_hi) + 16'h1)
        else $error("seconds overflow not flagged");

    pps_on_second_a: assert property (
        pps_out |-> $past(s_q.now.sec) != s_q.now.sec)
        else $error("pulse without second advance");

    capture_spacing_a: assert property (
        $rose(s_q.tx_stamp_ok) || $rose(s_q.rx_stamp_ok)
        |=> !$rose(s_q.tx_stamp_ok) [*2])
        else $error("captures closer than three cycles");

    tx_wb_pair_a: assert property (
        tx_frame_done |=> tx_wb.valid && tx_wb.status == $past(tx_status)
        && tx_wb.tx_desc_stamp_low_word == $past(s_q.tx_stamp[31:0]))
        else $error("transmit write-back mismatch");

    rx_last_only_a: assert property (
        rx_wb.stamp_we |-> $past(rx_frame_done) && $past(rx_last_desc))
        else $error("receive stamp outside last descriptor");

    rx_invalid_ones_a: assert property (
        ptc_rx_bad_end |=> ptc_rx_ones_out)
        else $error("invalid receive stamp not all ones");

    rx_disabled_keep_a: assert property (
        rx_frame_done && !s_q.ctrl[PTC_CTRL_ENABLE_BIT] |=> !rx_wb.stamp_we)
        else $error("receive words written while disabled");

    bus_answer_a: assert property (
        req_any && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer later than one cycle");

endmodule : ptc_timestamp_capture

`default_nettype wire

/* ptc_phy_model.sv */
// Far-side model: PHY interface clock and start-of-frame marks
`timescale 1ns/1ps
`default_nettype none

module ptc_phy_model
(
    output logic phy_clk,
    output logic tx_sfd,
    output logic rx_sfd,
    output logic tx_stamp_req
);
    // ****************************************
    // Interface clock
    // ****************************************
    // Free running, as a line clock is; 160 ns period
    initial
    begin
        phy_clk = 1'b0;
        forever #80 phy_clk = ~phy_clk;
    end

    // Marks idle low from time zero
    initial
    begin
        tx_sfd = 1'b0;
        rx_sfd = 1'b0;
        tx_stamp_req = 1'b0;
    end

    // ****************************************
    // Delimiter generation
    // ****************************************
    // Launched on the falling edge so each mark is settled at the rising
    // edge; follow puts a receive mark one interface cycle after a send
    task automatic send(input logic is_tx, input logic req,
                        input logic follow);
        @(negedge phy_clk);
        tx_sfd <= is_tx;
        rx_sfd <= !is_tx;
        tx_stamp_req <= req & is_tx;
        @(negedge phy_clk);
        tx_sfd <= 1'b0;
        rx_sfd <= follow;
        tx_stamp_req <= 1'b0;
        @(negedge phy_clk);
        rx_sfd <= 1'b0;
    endtask : send
endmodule : ptc_phy_model

`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the stamp capture block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import ptc_pkg::*;
    logic mclk, resetn, tx_frame_done, rx_frame_done;
    logic rx_last_desc, rx_overflow, pps_out, avs_waitrequest;
    logic phy_clk, tx_sfd, rx_sfd, tx_stamp_req;
    logic [31:0] tx_status, avs_readdata, rd, lfsr_q, ref_ns;
    logic [31:0] tx_ref, rx_ref, incr_m, t0, win_lag;
    ptc_avs_req_t avs_req;
    ptc_txwb_t tx_wb;
    ptc_rxwb_t rx_wb;
    ptc_time_t time_now;
    int err_total, total_checks;

    ptc_timestamp_capture dut_u (.mclk(mclk), .resetn(resetn),
        .avs_req(avs_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .phy_clk(phy_clk),
        .tx_sfd(tx_sfd), .tx_stamp_req(tx_stamp_req), .rx_sfd(rx_sfd),
        .tx_frame_done(tx_frame_done), .tx_status(tx_status),
        .rx_frame_done(rx_frame_done), .rx_last_desc(rx_last_desc),
        .rx_overflow(rx_overflow), .tx_wb(tx_wb), .rx_wb(rx_wb),
        .pps_out(pps_out), .time_now(time_now));

    ptc_phy_model phy_u (.phy_clk(phy_clk), .tx_sfd(tx_sfd),
        .rx_sfd(rx_sfd), .tx_stamp_req(tx_stamp_req));

    // ****************************************
    // Clock, expected time and watchdog
    // ****************************************
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Own count of reference time; exact offset to the block is unknown
    always @(posedge mclk)
        ref_ns <= !resetn ? 32'h0 : ref_ns + incr_m;

    // Expected stamp is the time at the interface edge that carries SFD
    always @(posedge phy_clk)
    begin
        if (tx_sfd)
            tx_ref = ref_ns;
        if (rx_sfd)
            rx_ref = ref_ns;
    end

    // A few hundred cycles are needed; 20000 means a hang
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_total++;
        give_verdict();
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
    endfunction : lfsr

    // Stamp may not precede the SFD edge, nor lag it by more than win_lag
    function automatic logic in_win(input logic [31:0] s,
                                    input logic [31:0] r);
        return (s >= r) && (s - r <= win_lag);
    endfunction : in_win

    // An unknown result counts as a mismatch, not as a pass
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    // One bus access; waitrequest and read data taken at the same edge
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] wd);
        int n;
        logic w;
        n = 0;
        @(posedge mclk);
        avs_req <= '{!wr, wr, a, wd, 4'hF};
        do
        begin
            @(posedge mclk);
            w = avs_waitrequest;
            rd = avs_readdata;
            n++;
        end
        while (w !== 1'b0 && n < 50);
        avs_req <= '{1'b0, 1'b0, 6'h00, 32'h0, 4'hF};
        chk(n < 50, "bus answer missing");
    endtask : bus

    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd === exp, "register read value");
    endtask : rdchk

    task automatic step_chk();
        @(negedge mclk);
        t0 = time_now.ns;
        @(negedge mclk);
        chk(time_now.ns - t0 === incr_m, "time step");
        chk(time_now.sec === 32'h0, "seconds half");
    endtask : step_chk

    // Frame completion pulse; returns mid-cycle after the write-back
    task automatic frame(input logic is_tx, input logic last,
                         input logic ovf, input logic [31:0] st);
        @(posedge mclk);
        tx_frame_done <= is_tx;
        rx_frame_done <= !is_tx;
        rx_last_desc <= last;
        rx_overflow <= ovf;
        tx_status <= st;
        @(posedge mclk);
        tx_frame_done <= 1'b0;
        rx_frame_done <= 1'b0;
        @(negedge mclk);
    endtask : frame

    task automatic rx_case(input logic last, input logic ovf,
                           input logic we);
        phy_u.send(1'b0, 1'b0, 1'b0);
        repeat (16) @(posedge mclk);
        frame(1'b0, last, ovf, 32'h0);
        chk(rx_wb.valid === 1'b1 && rx_wb.stamp_we === we, "rx flags");
    endtask : rx_case

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        {tx_frame_done, rx_frame_done, rx_last_desc, rx_overflow} = 4'h0;
        tx_status = 32'h0;
        avs_req = '{1'b0, 1'b0, 6'h00, 32'h0, 4'hF};
        err_total = 0;
        total_checks = 0;
        incr_m = 32'(PTC_INCR_RESET);
        lfsr_q = 32'h0001_0568;
        resetn = 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        // Reset values, an unmapped place and a read-only write
        rdchk(PTC_REG_CTRL, 32'(PTC_CTRL_RESET));
        rdchk(PTC_REG_INCR, 32'(PTC_INCR_RESET));
        rdchk(PTC_REG_PPS, 32'(PTC_PPS_RESET));
        rdchk(PTC_REG_STATUS, 32'h0);
        rdchk(PTC_REG_SEC_HI, 32'h0);
        rdchk(6'h3C, 32'h0);
        bus(1'b1, PTC_REG_SEC, 32'h0000_0055);
        rdchk(PTC_REG_SEC, 32'h0);
        bus(1'b1, PTC_REG_CTRL, 32'h0);
        rdchk(PTC_REG_CTRL, 32'h0);
        step_chk();
        $display("test registers done");
        // Transmit stamps, requested and not, with random status
        bus(1'b1, PTC_REG_CTRL, 32'h3);
        // Transmit lag limit: two reference clocks
        win_lag = {incr_m[30:0], 1'b0};
        for (int i = 0; i < 4; i++)
        begin
            lfsr_q = lfsr(lfsr_q);
            phy_u.send(1'b1, !i[0], 1'b0);
            repeat (16) @(posedge mclk);
            frame(1'b1, 1'b0, 1'b0, lfsr_q);
            chk(tx_wb.valid === 1'b1, "tx write-back");
            chk(tx_wb.status === lfsr_q, "tx status");
            chk(tx_wb.stamp_ok === !i[0], "tx stamp flag");
            if (!i[0])
            begin
                chk(in_win(tx_wb.tx_desc_stamp_low_word, tx_ref),
                    "tx ns");
                chk(tx_wb.tx_desc_stamp_high_word === 32'h0, "tx s");
            end
        end
        $display("test transmit done");
        // Receive: middle descriptor, last, overflow
        // Receive adds three interface clocks of 160 ns to the limit
        win_lag = win_lag + 32'h1E0;
        rx_case(1'b0, 1'b0, 1'b0);
        rx_case(1'b1, 1'b0, 1'b1);
        chk(in_win(rx_wb.rx_desc_stamp_low_word, rx_ref),
            "rx ns");
        chk(rx_wb.rx_desc_stamp_high_word === 32'h0, "rx s");
        rx_case(1'b1, 1'b1, 1'b1);
        chk(rx_wb.rx_desc_stamp_low_word === PTC_WORD_ONES, "ovf low");
        chk(rx_wb.rx_desc_stamp_high_word === PTC_WORD_ONES, "ovf hi");
        $display("test receive done");
        // Receive SFD one interface cycle after a transmit one is skipped
        phy_u.send(1'b1, 1'b1, 1'b1);
        repeat (16) @(posedge mclk);
        frame(1'b1, 1'b0, 1'b0, 32'h0);
        chk(tx_wb.stamp_ok === 1'b1, "first of close pair");
        frame(1'b0, 1'b1, 1'b0, 32'h0);
        chk(rx_wb.rx_desc_stamp_low_word === PTC_WORD_ONES, "skip");
        // Stamping off leaves the receive words alone
        bus(1'b1, PTC_REG_CTRL, 32'h2);
        rx_case(1'b1, 1'b0, 1'b0);
        $display("test spacing and disable done");
        // Random step size, pulse interval and status clear
        lfsr_q = lfsr(lfsr_q);
        incr_m = {24'h0, lfsr_q[7:1], 1'b1};
        bus(1'b1, PTC_REG_INCR, incr_m);
        rdchk(PTC_REG_INCR, incr_m);
        step_chk();
        bus(1'b1, PTC_REG_PPS, {24'h0, lfsr_q[15:8]});
        rdchk(PTC_REG_PPS, {24'h0, lfsr_q[15:8]});
        bus(1'b1, PTC_REG_STATUS, 32'h1);
        rdchk(PTC_REG_STATUS, 32'h0);
        chk(pps_out === 1'b0, "no pulse within first second");
        $display("test random settings done");
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
